/* hdl/tpp_top.sv */
// Translation protection, parity and prefetch offset logic with AHB regs
// Behaviour
// - Entry: frame, access code, modified, valid, offset, parity
// - Lookup indexed by access code, modified, check type, mode
// - Access code grants none, read or read/write per mode
// - Check type 00 none, 01 write, 10 read; 11 unused
// - Mode 00 kernel, 01 executive, 10 supervisor, 11 user
// - Access denial when mode and check type forbid page
// - Modify denial on write to unmodified page
// - Each denial sets status bit and error summary
// - Lookup gives parity over access code and modified
// - Composite parity of frame, offset, valid, lookup; force input
// - Parity mismatch sets status bit and error summary
// - Entry write stores generated composite parity
// - Physical mode puts address bits 23:9 as frame
// - Physical select on unmapped CPU op, held by latch
// - Physical select disables buffer and checks
// - Fill read pulses load, seeds counter with offset plus one
// - Prefetch addresses array with counter offset
// - Each clean prefetch pulses load and advances counter
// - Counter wraps full to zero, raising page-wrap flag
// - Prefetch select drives offset from counter
// - Control bit 19 low sets prefetch select; grant, latch hold
// - Tag mismatch: miss, status bit, error summary
//
// Local design decisions: the AHB-Lite register port and the register offsets.
module tpp_top (
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    // AHB-Lite slave
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    // CPU side
    input  wire logic                         cpu_req,
    input  wire logic                         cpu_grant,
    input  wire logic                         cpu_owner_flag,
    input  wire logic                         mapping_enable,
    input  wire logic                         controller_function_latch,
    input  wire logic                         istream_ctrl_bit,
    input  wire logic                         checked_fill_read,
    input  wire logic [1:0]                   check_type_bits,
    input  wire logic [1:0]                   current_mode_bits,
    input  wire logic [31:0]                  latched_vaddr,
    // Results
    output logic [23:2]                       phys_addr,
    output logic                              access_done,
    output logic                              no_permission_flag,
    output logic                              dirty_needed_flag,
    output logic                              entry_parity_fault,
    output logic                              translation_miss,
    output logic                              error_summary,
    output logic                              instr_buffer_load,
    output logic                              prefetch_page_wrap,
    output logic                              physical_mode_select,
    output logic                              prefetch_select
);
    import tpp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Storage and state
    logic [TPP_ENT_W-1:0]  tb_r [0:TPP_DEPTH-1];
    logic [TPP_TAG_W-1:0]  tag_r [0:TPP_DEPTH-1];
    logic [TPP_ST_W-1:0]   status_r;
    logic [TPP_ST_W-1:0]   status_nxt;
    logic                  force_par_r;
    logic [TPP_ENT_W-2:0]  stage_r;
    logic [TPP_TAG_W-1:0]  stage_tag_r;
    logic [TPP_IDX_W-1:0]  stage_idx_r;
    logic [TPP_IDX_W-1:0]  pf_cnt_r;
    logic [TPP_IDX_W-1:0]  pf_cnt_nxt;
    logic                  wrap_r;
    logic                  wrap_nxt;
    logic                  fill_seen_r;
    logic                  psel_nxt;
    logic                  pfsel_nxt;

    // AHB-Lite data-phase tracking
    logic                  dp_wr_r;
    logic [7:0]            dp_addr_r;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite decode
    logic       ap_valid;
    logic       ap_read;
    logic [7:0] ap_ofs;
    logic       wr_status;
    logic       wr_control;
    logic       wr_entry;
    logic       wr_tagidx;
    logic [31:0] rd_mux;

    // Address phase taken only when selected, active and bus ready
    assign ap_valid = hsel & htrans[1] & hready;
    assign ap_read  = ap_valid & ~hwrite;
    assign ap_ofs   = haddr[7:0];

    assign wr_status  = dp_wr_r & (dp_addr_r == TPP_OFS_STATUS);
    assign wr_control = dp_wr_r & (dp_addr_r == TPP_OFS_CONTROL);
    assign wr_entry   = dp_wr_r & (dp_addr_r == TPP_OFS_ENTRY);
    assign wr_tagidx  = dp_wr_r & (dp_addr_r == TPP_OFS_TAGIDX);

    // Read mux; unmapped offsets answer zero, still OKAY
    assign rd_mux =
        (ap_ofs == TPP_OFS_STATUS)  ? {28'h0000000, status_r} :
        (ap_ofs == TPP_OFS_CONTROL) ? {31'h00000000, force_par_r} :
        (ap_ofs == TPP_OFS_ENTRY)   ? {10'h000, stage_r} :
        (ap_ofs == TPP_OFS_TAGIDX)  ? {9'h000, stage_idx_r, stage_tag_r} :
        (ap_ofs == TPP_OFS_PREF)    ? {22'h000000, fill_seen_r, wrap_r,
                                       1'b0, pf_cnt_r} :
                                      32'h00000000;

    // Zero wait states: read data is loaded at the address-phase edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            dp_wr_r   <= ap_valid & hwrite;
            dp_addr_r <= ap_ofs;
            if (ap_read) begin
                hrdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and staging registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            force_par_r <= 1'b0;
            stage_r     <= TPP_ENT_RST[TPP_ENT_W-2:0];
            stage_tag_r <= 16'h0000;
            stage_idx_r <= TPP_CNT_RST;
        end else begin
            if (wr_control) begin
                force_par_r <= hwdata[0];
            end
            if (wr_entry) begin
                stage_r <= hwdata[TPP_ENT_W-2:0];
            end
            if (wr_tagidx) begin
                stage_tag_r <= hwdata[TPP_TAG_W-1:0];
                stage_idx_r <= hwdata[TPP_TAGIDX_IDX +: TPP_IDX_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Select latches for physical mode and prefetch
    // Physical select latches itself while the function latch stays up
    assign psel_nxt = (cpu_req & cpu_owner_flag & ~mapping_enable)
                    | (physical_mode_select & controller_function_latch);
    // Control bit 19 low requests prefetch; grant captures, latch holds
    assign pfsel_nxt = (~istream_ctrl_bit & cpu_grant)
                     | (prefetch_select & controller_function_latch);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            physical_mode_select <= 1'b0;
            prefetch_select      <= 1'b0;
        end else begin
            physical_mode_select <= psel_nxt;
            prefetch_select      <= pfsel_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lookup of the indexed entry
    logic [TPP_IDX_W-1:0]   rd_idx;
    logic [TPP_ENT_W-1:0]   ent;
    logic [TPP_TAG_W-1:0]   ent_tag;
    logic                   xlate;
    logic                   use_pf;
    logic                   deny_acc;
    logic                   deny_mod;
    logic                   lut_par;
    logic                   comp_par;
    logic                   par_bad;
    logic                   tag_bad;
    logic [TPP_IDX_W-1:0]   offset;
    logic [14:0]            frame_sel;

    // CPU index: address bit 31 on top of bits 14:9
    assign rd_idx  = {latched_vaddr[31], latched_vaddr[14:9]};
    assign ent     = tb_r[rd_idx];
    assign ent_tag = tag_r[rd_idx];

    // Buffer is only consulted outside physical mode
    assign xlate = cpu_req & ~psel_nxt;

    tpp_perm_lookup u_perm (
        .access_code_bits          (ent[TPP_ENT_ACC +: 4]),
        .modified                  (ent[TPP_ENT_MOD]),
        .check_type_bits           (check_type_bits),
        .current_mode_bits         (current_mode_bits),
        .no_permission             (deny_acc),
        .dirty_needed              (deny_mod),
        .permission_partial_parity (lut_par)
    );

    // Composite parity over every stored bit plus the diagnostic force
    assign comp_par = (^{ent[TPP_FRAME_W-1:0], ent[TPP_ENT_BOF]})
                    ^ ent[TPP_ENT_VAL] ^ lut_par ^ force_par_r;
    assign par_bad  = comp_par != ent[TPP_ENT_PAR];
    assign tag_bad  = ent_tag != latched_vaddr[30:15];

    // Offset lines: counter while prefetching, CPU address bits 8:2 otherwise
    assign use_pf    = pfsel_nxt;
    assign offset    = use_pf ? pf_cnt_r : latched_vaddr[8:2];
    // Physical mode bypasses the frame number with address bits 23:9
    assign frame_sel = psel_nxt ? latched_vaddr[23:9]
                                : ent[TPP_FRAME_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Entry writes with generated parity
    logic [TPP_ENT_W-2:0] new_ent;
    logic                 new_par;

    assign new_ent = stage_r;
    // Same generator as the read side, so a forced bit plants a bad entry
    assign new_par = (^{new_ent[TPP_FRAME_W-1:0], new_ent[TPP_ENT_BOF]})
                   ^ new_ent[TPP_ENT_VAL]
                   ^ (^{new_ent[TPP_ENT_ACC +: 4], new_ent[TPP_ENT_MOD]})
                   ^ force_par_r;

    // Commit on the tag-and-index write; no reset, contents are loaded
    always_ff @(posedge core_clk) begin
        if (wr_tagidx) begin
            tb_r[hwdata[TPP_TAGIDX_IDX +: TPP_IDX_W]]
                <= {new_par, new_ent};
            tag_r[hwdata[TPP_TAGIDX_IDX +: TPP_IDX_W]]
                <= hwdata[TPP_TAG_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error events and first status register
    logic ev_acc;
    logic ev_mod;
    logic ev_par;
    logic ev_miss;
    logic [TPP_ST_W-1:0] ev_vec;
    logic [TPP_ST_W-1:0] clr_vec;
    logic good_read;

    // Flags counted only for a translated access
    assign ev_miss = xlate & tag_bad;
    assign ev_par  = xlate & ~tag_bad & par_bad;
    assign ev_acc  = xlate & ~tag_bad & deny_acc;
    assign ev_mod  = xlate & ~tag_bad & deny_mod;

    assign ev_vec  = {ev_miss, ev_par, ev_mod, ev_acc};
    assign clr_vec = wr_status ? hwdata[TPP_ST_W-1:0] : TPP_ST_RST;
    // Write-one-to-clear, and a new event in the same cycle wins
    assign status_nxt = (status_r & ~clr_vec) | ev_vec;

    // Clean read completes and loads the instruction buffer
    assign good_read = cpu_req & (checked_fill_read | use_pf)
                     & ~(ev_miss | ev_par | ev_acc | ev_mod);

    ////////////////////////////////////////////////////////////////////////
    // Prefetch counter
    logic [TPP_IDX_W-1:0] pf_base;

    // Fill read seeds from the CPU offset, prefetch reloads its own output
    assign pf_base    = use_pf ? pf_cnt_r : latched_vaddr[8:2];
    assign pf_cnt_nxt = good_read ? (pf_base + 7'h01) : pf_cnt_r;
    // Wrap flag raised at full count; the next prefetch re-translates
    assign wrap_nxt   = good_read ? (pf_base == TPP_CNT_FULL)
                      : ((cpu_req & use_pf) ? 1'b0 : wrap_r);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pf_cnt_r    <= TPP_CNT_RST;
            wrap_r      <= 1'b0;
            fill_seen_r <= 1'b0;
        end else begin
            pf_cnt_r <= pf_cnt_nxt;
            wrap_r   <= wrap_nxt;
            // Readable hint that the CPU seeded the counter first
            if (cpu_req & checked_fill_read) begin
                fill_seen_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs toward CPU and arrays
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_r           <= TPP_ST_RST;
            phys_addr          <= 22'h000000;
            access_done        <= 1'b0;
            no_permission_flag <= 1'b0;
            dirty_needed_flag  <= 1'b0;
            entry_parity_fault <= 1'b0;
            translation_miss   <= 1'b0;
            error_summary      <= 1'b0;
            instr_buffer_load  <= 1'b0;
        end else begin
            status_r           <= status_nxt;
            access_done        <= cpu_req;
            no_permission_flag <= ev_acc;
            dirty_needed_flag  <= ev_mod;
            entry_parity_fault <= ev_par;
            translation_miss   <= ev_miss;
            error_summary      <= |status_nxt;
            instr_buffer_load  <= good_read;
            if (cpu_req) begin
                phys_addr <= {frame_sel, offset};
            end
        end
    end

    // Page-wrap flag is shown directly from its register
    assign prefetch_page_wrap = wrap_r;

endmodule // tpp_top

/* hdl/tpp_pkg.sv */
// Shared constants for the translation protection and prefetch block
package tpp_pkg;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] TPP_OFS_STATUS  = 8'h00;
    localparam logic [7:0] TPP_OFS_CONTROL = 8'h04;
    localparam logic [7:0] TPP_OFS_ENTRY   = 8'h08;
    localparam logic [7:0] TPP_OFS_TAGIDX  = 8'h0c;
    localparam logic [7:0] TPP_OFS_PREF    = 8'h10;

    // First status register bit positions
    localparam int TPP_ST_ACCESS = 0;
    localparam int TPP_ST_MODIFY = 1;
    localparam int TPP_ST_PARITY = 2;
    localparam int TPP_ST_MISS   = 3;
    localparam int TPP_ST_W      = 4;

    // Entry layout: frame, access code, modified, valid, byte offset
    localparam int TPP_FRAME_W = 15;
    localparam int TPP_ENT_ACC = 15;
    localparam int TPP_ENT_MOD = 19;
    localparam int TPP_ENT_VAL = 20;
    localparam int TPP_ENT_BOF = 21;
    localparam int TPP_ENT_PAR = 22;
    localparam int TPP_ENT_W   = 23;
    localparam int TPP_TAG_W   = 16;
    localparam int TPP_IDX_W   = 7;
    localparam int TPP_DEPTH   = 128;
    localparam int TPP_TAGIDX_IDX = 16;

    // Reset values and the full counter count
    localparam logic [TPP_ST_W-1:0]    TPP_ST_RST  = 4'h0;
    localparam logic [TPP_ENT_W-1:0]   TPP_ENT_RST = 23'h000000;
    localparam logic [TPP_IDX_W-1:0]   TPP_CNT_RST = 7'h00;
    localparam logic [TPP_IDX_W-1:0]   TPP_CNT_FULL = 7'h7f;

    // Check-type codes
    localparam logic [1:0] TPP_CHK_NONE  = 2'h0;
    localparam logic [1:0] TPP_CHK_WRITE = 2'h1;
    localparam logic [1:0] TPP_CHK_READ  = 2'h2;

    // Allowed-mode masks indexed by {access code, mode}; bit set = allowed
    localparam logic [63:0] TPP_READ_OK  = 64'hffff_7777_333f_1100;
    localparam logic [63:0] TPP_WRITE_OK = 64'h0137_0137_013f_0100;

endpackage

/* hdl/tpp_perm_lookup.sv */
// Permission lookup: denial flags and partial parity from nine inputs
module tpp_perm_lookup (
    input  wire logic [3:0] access_code_bits,
    input  wire logic       modified,
    input  wire logic [1:0] check_type_bits,
    input  wire logic [1:0] current_mode_bits,
    output logic            no_permission,
    output logic            dirty_needed,
    output logic            permission_partial_parity
);
    import tpp_pkg::*;

    logic [5:0] lut_idx;
    logic       rd_ok;
    logic       wr_ok;
    logic       is_wr;
    logic       is_rd;

    // Six-bit index: code and mode pick a table bit, type picks table
    assign lut_idx = {access_code_bits, current_mode_bits};
    assign rd_ok   = TPP_READ_OK[lut_idx];
    assign wr_ok   = TPP_WRITE_OK[lut_idx];
    assign is_wr   = (check_type_bits == TPP_CHK_WRITE);
    assign is_rd   = (check_type_bits == TPP_CHK_READ);

    // Code 11 is never issued, so it simply falls through as no check
    assign no_permission = (is_wr & ~wr_ok) | (is_rd & ~rd_ok);
    // Modify refusal only once access itself is granted
    assign dirty_needed  = is_wr & wr_ok & ~modified;
    assign permission_partial_parity = ^{access_code_bits, modified};

endmodule // tpp_perm_lookup

/* bench/tpp_top_checker.sv */
// Port-level assertions for the translation protection and prefetch block
module tpp_top_checker import tpp_pkg::*; (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        checked_fill_read,
    input wire logic        istream_ctrl_bit,
    input wire logic        controller_function_latch,
    input wire logic [1:0]  check_type_bits,
    input wire logic [31:0] latched_vaddr,
    input wire logic [23:2] phys_addr,
    input wire logic        access_done,
    input wire logic        no_permission_flag,
    input wire logic        dirty_needed_flag,
    input wire logic        entry_parity_fault,
    input wire logic        translation_miss,
    input wire logic        error_summary,
    input wire logic        instr_buffer_load,
    input wire logic        prefetch_page_wrap,
    input wire logic        physical_mode_select,
    input wire logic        prefetch_select
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Any result flag; summary must never lag behind it
    logic       any_flag;
    logic [6:0] cnt_r;
    assign any_flag = no_permission_flag | dirty_needed_flag |
                      entry_parity_fault | translation_miss;
    // Shadow offset: only buffer loads move it, so a stuck counter shows
    always_ff @(posedge core_clk) begin
        if (rst)
            cnt_r <= 7'h00;
        else if (instr_buffer_load)
            cnt_r <= phys_addr[8:2] + 7'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    a_phys_quiet: assert property (
        access_done && physical_mode_select |-> !any_flag)
        else $error("check reported in physical mode");
    a_phys_bypass: assert property (
        access_done && physical_mode_select
        |-> phys_addr[23:9] == $past(latched_vaddr[23:9]))
        else $error("physical bits not bypassed");
    a_phys_hold: assert property (
        physical_mode_select && controller_function_latch
        |=> physical_mode_select)
        else $error("physical select dropped under latch");
    a_pref_hold: assert property (
        prefetch_select && controller_function_latch |=> prefetch_select)
        else $error("prefetch select dropped under latch");
    a_err_summary: assert property (
        any_flag |-> error_summary)
        else $error("flag without error summary");
    a_dirty_write: assert property (
        dirty_needed_flag
        |-> $past(check_type_bits) == TPP_CHK_WRITE && !no_permission_flag)
        else $error("modify denial outside a write");
    a_none_quiet: assert property (
        access_done && $past(check_type_bits) == TPP_CHK_NONE
        |-> !no_permission_flag && !dirty_needed_flag)
        else $error("denial with no check requested");
    a_pref_offset: assert property (
        access_done && !physical_mode_select && $past(!istream_ctrl_bit)
        |-> phys_addr[8:2] == cnt_r)
        else $error("prefetch offset not from counter");
    a_wrap_flag: assert property (
        instr_buffer_load && phys_addr[8:2] == 7'h7f |-> prefetch_page_wrap)
        else $error("no page wrap at full count");
    a_load_cause: assert property (
        instr_buffer_load
        |-> access_done && $past(checked_fill_read || !istream_ctrl_bit))
        else $error("buffer load without fill or prefetch");
    c_denial: cover property (no_permission_flag);
    c_wrap: cover property (instr_buffer_load && prefetch_page_wrap);
    c_phys: cover property (access_done && physical_mode_select);
endmodule // tpp_top_checker

bind tpp_top tpp_top_checker chk_u (.*);

/* bench/tpp_cpu_model.sv */
// CPU microcode partner: issues one controller access at a time
module tpp_cpu_model import tpp_pkg::*; (
    input  wire logic  core_clk,
    output logic       cpu_req,
    output logic       cpu_grant,
    output logic       cpu_owner_flag,
    output logic       mapping_enable,
    output logic       controller_function_latch,
    output logic       istream_ctrl_bit,
    output logic       checked_fill_read,
    output logic [1:0] check_type_bits,
    output logic [1:0] current_mode_bits,
    output logic [31:0] latched_vaddr
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle levels at time zero: CPU owns, mapping on, no prefetch
    initial begin
        {cpu_req, cpu_grant, checked_fill_read} = 3'h0;
        {cpu_owner_flag, mapping_enable, istream_ctrl_bit} = 3'h7;
        controller_function_latch = 1'b0;
        {check_type_bits, current_mode_bits} = 4'h0;
        latched_vaddr = 32'h0;
    end
    // Level controls change just after an edge
    task automatic set_mode(input logic me, own, lat);
        @(posedge core_clk);
        mapping_enable <= me;
        cpu_owner_flag <= own;
        controller_function_latch <= lat;
    endtask
    // One request cycle; returns mid-cycle once results have landed
    task automatic op(input logic fill, pref, input logic [1:0] ct, md,
                      input logic [31:0] va);
        @(posedge core_clk);
        cpu_req <= 1'b1;
        checked_fill_read <= fill;
        istream_ctrl_bit <= ~pref;
        cpu_grant <= pref;
        check_type_bits <= (ct == 2'h3) ? TPP_CHK_NONE : ct;
        current_mode_bits <= md;
        latched_vaddr <= va;
        @(posedge core_clk);
        {cpu_req, checked_fill_read, cpu_grant} <= 3'h0;
        istream_ctrl_bit <= 1'b1;
        latched_vaddr <= ~va; // Released bus must not show the old address
        @(negedge core_clk);
    endtask
endmodule // tpp_cpu_model

/* bench/tlb_protect_prefetch_tb.sv */
// Self-checking bench: random protection trials, parity, bypass, prefetch
module tlb_protect_prefetch_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tpp_pkg::*;
    logic        core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, va;
    logic [23:2] phys_addr;
    logic        hreadyout, hresp, access_done, no_permission_flag;
    logic        dirty_needed_flag, entry_parity_fault, translation_miss;
    logic        error_summary, instr_buffer_load, prefetch_page_wrap;
    logic        physical_mode_select, prefetch_select, cpu_req, cpu_grant;
    logic        cpu_owner_flag, mapping_enable, controller_function_latch;
    logic        istream_ctrl_bit, checked_fill_read, m, bof, hit;
    logic [1:0]  check_type_bits, current_mode_bits, ct, md;
    logic [3:0]  ac, e;
    logic [14:0] fr;
    logic [6:0]  idx, off;
    logic [15:0] tag;
    logic [63:0] r;
    int          n_fail = 0, check_count = 0, cyc = 0, seed = 32'h81fa;
    logic [31:0] va_bus;
    tpp_top dut_u (.hsize(3'h2), .hready(hreadyout),
        .latched_vaddr(va_bus), .*);
    tpp_cpu_model cpu_u (.latched_vaddr(va_bus), .*);
    ////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling so a hang still ends in a verdict
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string s);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t %s", $time, s);
        end
    endtask
    // Single AHB word transfer; waits on hready at each phase
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        @(posedge core_clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Reference result {miss, parity, modify, access} from the mode tables
    function automatic logic [3:0] ref_flags(logic [3:0] a, logic md_m,
                                 logic [1:0] c, logic [1:0] mo, logic h);
        int i;
        i = a * 4 + mo;
        if (!h)
            return 4'h8;
        if (c == TPP_CHK_READ)
            return {3'h0, ~TPP_READ_OK[i]};
        if (c == TPP_CHK_WRITE)
            return {2'h0, TPP_WRITE_OK[i] & ~md_m, ~TPP_WRITE_OK[i]};
        return 4'h0;
    endfunction
    task automatic put_entry(input logic [31:0] ent, input logic [6:0] ix,
                             input logic [15:0] tg);
        ahb(1'b1, TPP_OFS_ENTRY, ent, q);
        ahb(1'b1, TPP_OFS_TAGIDX, {9'h0, ix, tg}, q);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk({hreadyout, hresp, error_summary}, 3'h4, "reset outputs");
        ahb(1'b0, 8'h20, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        // Random entries, codes and modes; every trial checked and cleared
        repeat (48) begin
            r = {$random(seed), $random(seed)};
            {ac, md, m, bof, hit, fr, idx, off, tag} = r[53:0];
            ct = 2'($unsigned($random(seed)) % 3);
            put_entry({10'h0, bof, 1'b1, m, ac, fr}, idx, tag);
            va = {idx[6], hit ? tag : ~tag, idx[5:0], off, 2'h0};
            cpu_u.op(1'b0, 1'b0, ct, md, va);
            e = ref_flags(ac, m, ct, md, hit);
            chk({translation_miss, entry_parity_fault, dirty_needed_flag,
                 no_permission_flag}, e, "flags");
            chk(error_summary, |e, "summary");
            if (hit)
                chk(phys_addr, {fr, off}, "frame");
            ahb(1'b0, TPP_OFS_STATUS, 32'h0, q);
            chk(q[3:0], e, "status");
            ahb(1'b1, TPP_OFS_STATUS, 32'hf, q);
        end
        // Forced parity: stored bit no longer agrees with the check
        put_entry(32'h000a_1234, 7'h05, 16'h00ab);
        va = {1'b0, 16'h00ab, 6'h05, 7'h7e, 2'h0};
        ahb(1'b1, TPP_OFS_CONTROL, 32'h1, q);
        cpu_u.op(1'b0, 1'b0, TPP_CHK_READ, 2'h0, va);
        chk({entry_parity_fault, error_summary}, 2'h3, "par");
        ahb(1'b1, TPP_OFS_CONTROL, 32'h0, q);
        ahb(1'b1, TPP_OFS_STATUS, 32'hf, q);
        cpu_u.op(1'b0, 1'b0, TPP_CHK_READ, 2'h0, va);
        chk(entry_parity_fault, 1'b0, "stored parity");
        // Physical mode: bypass, no checks, held while the latch stands
        cpu_u.set_mode(1'b0, 1'b1, 1'b1);
        cpu_u.op(1'b0, 1'b0, TPP_CHK_WRITE, 2'h3, 32'h00abcdec);
        chk({phys_addr, translation_miss}, {22'h2af37b, 1'b0}, "ph");
        cpu_u.set_mode(1'b1, 1'b1, 1'b1);
        cpu_u.op(1'b0, 1'b0, TPP_CHK_READ, 2'h3, 32'h0012_3458);
        chk({physical_mode_select, phys_addr}, {1'b1, 22'h048d16}, "hold");
        cpu_u.set_mode(1'b1, 1'b1, 1'b0);
        repeat (2) @(negedge core_clk);
        chk(physical_mode_select, 1'b0, "ph release");
        // Fill at offset 7e, then prefetches across the page end
        cpu_u.op(1'b1, 1'b0, TPP_CHK_READ, 2'h0, va);
        chk({instr_buffer_load, phys_addr[8:2]}, 8'hfe, "fill");
        cpu_u.op(1'b0, 1'b1, TPP_CHK_READ, 2'h0, va ^ 32'h44);
        chk({prefetch_select, instr_buffer_load, prefetch_page_wrap,
             phys_addr[8:2]}, 10'h3ff, "pref wrap");
        ahb(1'b0, TPP_OFS_PREF, 32'h0, q);
        chk(q[9:0], 10'h300, "counter");
        cpu_u.op(1'b0, 1'b1, TPP_CHK_READ, 2'h0, va);
        chk({prefetch_page_wrap, phys_addr[8:2]}, 8'h00, "pref next");
        tally_and_finish();
    end
endmodule // tlb_protect_prefetch_tb
